// ---- core/ipr_cfg.svh ----
// Constants of the interrupt priority resolver: sizes, offsets, fields, reset values
`ifndef IPR_CFG_SVH
`define IPR_CFG_SVH

`define IPR_NUM_SRC 54
`define IPR_SRC_W 6
`define IPR_LVL_W 3
`define IPR_IPL_W 4
`define IPR_ADDR_W 8
`define IPR_DATA_W 16
`define IPR_VEC_BASE 6'h08

`define IPR_SLOT_W 4
`define IPR_SLOTS_PER_REG 4
`define IPR_BITS_PER_REG 16

`define IPR_OFS_PRIO 8'h00
`define IPR_NUM_PRIO_REGS 14
`define IPR_OFS_FLAG 8'h10
`define IPR_OFS_EN 8'h14
`define IPR_NUM_FLAG_REGS 4
`define IPR_OFS_RESULT 8'h18
`define IPR_OFS_EVT_STAT 8'h19
`define IPR_OFS_EVT_MASK 8'h1A

`define IPR_PRIO_RST 3'h0
`define IPR_FLAG_RST 1'b0
`define IPR_EN_RST 1'b0
`define IPR_EVT_RST 2'h0

`define IPR_RES_VEC_LSB 0
`define IPR_RES_LVL_LSB 6
`define IPR_RES_REQ_BIT 15

`define IPR_EVT_W 2
`define IPR_EVT_REQ_BIT 0
`define IPR_EVT_OVR_BIT 1

`define IPR_RSV_A_LO 39
`define IPR_RSV_A_HI 40
`define IPR_RSV_B_LO 43
`define IPR_RSV_B_HI 53

`define IPR_SRC_EXT_A 0
`define IPR_SRC_EXT_B 16
`define IPR_SRC_EXT_C 23
`define IPR_SRC_EXT_D 36
`define IPR_SRC_EXT_E 37
`define IPR_SRC_SER_A_RX 9
`define IPR_SRC_SER_A_TX 10
`define IPR_SRC_SER_B_RX 24
`define IPR_SRC_SER_B_TX 25
`define IPR_SRC_CODEC 41
`define IPR_SRC_LVD 42

`endif

// ---- core/ipr_pkg.sv ----
// Types shared by the interrupt priority resolver
package ipr_pkg;
  typedef logic [2:0] ipr_level_t;
  typedef logic [5:0] ipr_src_t;
  typedef logic [5:0] ipr_vector_t;
  typedef logic [15:0] ipr_word_t;
endpackage

// ---- core/ipr_resolver.sv ----
// Interrupt priority resolver: flags, enables, priority slots and winner selection
`timescale 1ns/1ns
`include "ipr_cfg.svh"
//
// What this block does
// - Each source keeps a 3-bit level in the low bits of its 4-bit slot.
// - Slot bit 3 is not stored; reads zero, writes ignored.
// - Level 0 is lowest, level 7 is highest.
// - Equal levels are ordered by a fixed source order; one winner always.
// - Source order only breaks ties; a higher level always wins.
// - In a tie the smaller index wins; 0 best, 53 worst.
// - The source number itself is the tie-break index.
// - A late source at level 7 beats an early source at level 1.
// - Reported vector equals source number plus eight, 8 to 61.
// - External pin requests sit at sources 0, 16, 23, 36, 37.
// - Serial A receive/transmit at 9/10, serial B at 24/25.
// - Sources 39-40 and 43-53 are reserved and never request.
// - Codec done is source 41; reserved on variants without codec.
// - Low-voltage detect is source 42, vector 50.
// - A source at level zero is disabled and never presented.
// - Flags set on the event whatever the enable; software clears them.
// - Request the core only when winner level exceeds core level.

module ipr_resolver
  import ipr_pkg::*;
#(
  parameter bit HAS_CODEC = 1'b1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [`IPR_ADDR_W-1:0] regAddr,
  input wire logic [`IPR_DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [`IPR_DATA_W-1:0] regRdData,
  input wire logic [`IPR_NUM_SRC-1:0] periphEvent,
  input wire logic extPinIrqA,
  input wire logic extPinIrqB,
  input wire logic extPinIrqC,
  input wire logic extPinIrqD,
  input wire logic extPinIrqE,
  input wire logic serialAReceiveIrq,
  input wire logic serialATransmitIrq,
  input wire logic serialBReceiveIrq,
  input wire logic serialBTransmitIrq,
  input wire logic codecTransferIrq,
  input wire logic lowVoltageDetectIrq,
  input wire logic [`IPR_IPL_W-1:0] cpuPriorityLevel,
  output logic cpuIrqReq,
  output ipr_vector_t cpuIrqVector,
  output ipr_level_t cpuIrqLevel,
  output logic intOut
);

  ipr_level_t prioLevel_q [`IPR_NUM_SRC];
  logic [`IPR_NUM_SRC-1:0] flag_q;
  logic [`IPR_NUM_SRC-1:0] enable_q;
  logic [`IPR_NUM_SRC-1:0] srcEvent;
  logic [`IPR_NUM_SRC-1:0] reserved;
  logic [`IPR_NUM_SRC-1:0] eligible;
  logic [`IPR_EVT_W-1:0] evtStat_q;
  logic [`IPR_EVT_W-1:0] evtStat_d;
  logic [`IPR_EVT_W-1:0] evtMask_q;
  logic [`IPR_EVT_W-1:0] evtSet;
  logic [`IPR_EVT_W-1:0] evtClr;
  logic cpuIrqReq_q;
  ipr_vector_t cpuIrqVector_q;
  ipr_level_t cpuIrqLevel_q;
  logic intOut_q;
  ipr_word_t regRdData_q;
  ipr_word_t rdMux;
  logic [`IPR_DATA_W-1:0] prioWord [`IPR_NUM_PRIO_REGS];
  logic [`IPR_DATA_W-1:0] flagWord [`IPR_NUM_FLAG_REGS];
  logic [`IPR_DATA_W-1:0] enWord [`IPR_NUM_FLAG_REGS];
  logic bestValid;
  ipr_level_t bestLevel;
  ipr_src_t bestIdx;
  logic takeReq;

  assign regRdData = regRdData_q;
  assign cpuIrqReq = cpuIrqReq_q;
  assign cpuIrqVector = cpuIrqVector_q;
  assign cpuIrqLevel = cpuIrqLevel_q;
  assign intOut = intOut_q;

  // Named request lines are merged onto their fixed source numbers
  always_comb begin
    srcEvent = periphEvent;
    srcEvent[`IPR_SRC_EXT_A] = periphEvent[`IPR_SRC_EXT_A] | extPinIrqA;
    srcEvent[`IPR_SRC_EXT_B] = periphEvent[`IPR_SRC_EXT_B] | extPinIrqB;
    srcEvent[`IPR_SRC_EXT_C] = periphEvent[`IPR_SRC_EXT_C] | extPinIrqC;
    srcEvent[`IPR_SRC_EXT_D] = periphEvent[`IPR_SRC_EXT_D] | extPinIrqD;
    srcEvent[`IPR_SRC_EXT_E] = periphEvent[`IPR_SRC_EXT_E] | extPinIrqE;
    srcEvent[`IPR_SRC_SER_A_RX] = periphEvent[`IPR_SRC_SER_A_RX] | serialAReceiveIrq;
    srcEvent[`IPR_SRC_SER_A_TX] = periphEvent[`IPR_SRC_SER_A_TX] | serialATransmitIrq;
    srcEvent[`IPR_SRC_SER_B_RX] = periphEvent[`IPR_SRC_SER_B_RX] | serialBReceiveIrq;
    srcEvent[`IPR_SRC_SER_B_TX] = periphEvent[`IPR_SRC_SER_B_TX] | serialBTransmitIrq;
    srcEvent[`IPR_SRC_CODEC] = periphEvent[`IPR_SRC_CODEC] | codecTransferIrq;
    srcEvent[`IPR_SRC_LVD] = periphEvent[`IPR_SRC_LVD] | lowVoltageDetectIrq;
  end

  // Per-source storage: priority slot, request flag, enable bit
  genvar i;
  generate
    for (i = 0; i < `IPR_NUM_SRC; i++) begin : gSrc
      localparam int PREG = i / `IPR_SLOTS_PER_REG;
      localparam int PSLOT = i % `IPR_SLOTS_PER_REG;
      localparam int FREG = i / `IPR_BITS_PER_REG;
      localparam int FBIT = i % `IPR_BITS_PER_REG;
      logic prioHit;
      logic flagHit;
      logic enHit;
      ipr_level_t prioLevel_d;
      logic flag_d;
      logic enable_d;

      assign reserved[i] = ((i >= `IPR_RSV_A_LO) && (i <= `IPR_RSV_A_HI))
        || ((i >= `IPR_RSV_B_LO) && (i <= `IPR_RSV_B_HI))
        || ((i == `IPR_SRC_CODEC) && !HAS_CODEC);

      assign prioHit = regWrStb
        && (regAddr == `IPR_OFS_PRIO + `IPR_ADDR_W'(PREG));
      assign flagHit = regWrStb
        && (regAddr == `IPR_OFS_FLAG + `IPR_ADDR_W'(FREG));
      assign enHit = regWrStb
        && (regAddr == `IPR_OFS_EN + `IPR_ADDR_W'(FREG));

      // Only the low three slot bits are kept; bit 3 has no storage
      always_comb begin
        prioLevel_d = prioLevel_q[i];
        if (prioHit) begin
          prioLevel_d = regWrData[PSLOT*`IPR_SLOT_W +: `IPR_LVL_W];
        end
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          prioLevel_q[i] <= `IPR_PRIO_RST;
        end else begin
          prioLevel_q[i] <= prioLevel_d;
        end
      end

      // Event sets the flag even during a software write in the same cycle
      always_comb begin
        if (reserved[i]) begin
          flag_d = 1'b0;
        end else if (flagHit) begin
          flag_d = regWrData[FBIT] | srcEvent[i];
        end else begin
          flag_d = flag_q[i] | srcEvent[i];
        end
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          flag_q[i] <= `IPR_FLAG_RST;
        end else begin
          flag_q[i] <= flag_d;
        end
      end

      // A reserved source can never hold an enable, so it cannot reach the search
      always_comb begin
        enable_d = enable_q[i];
        if (enHit) begin
          enable_d = regWrData[FBIT] & ~reserved[i];
        end
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          enable_q[i] <= `IPR_EN_RST;
        end else begin
          enable_q[i] <= enable_d;
        end
      end

      assign eligible[i] = flag_q[i] && enable_q[i] && !reserved[i]
        && (prioLevel_q[i] != 3'h0);
    end
  endgenerate

  // One combinational chain over all sources; at this clock rate it fits, and
  // registering only the result keeps the core side one cycle behind the flags
  // Highest level wins; scanning downward with >= lets the lower index take ties
  always_comb begin
    bestValid = 1'b0;
    bestLevel = 3'h0;
    bestIdx = 6'h00;
    for (int k = `IPR_NUM_SRC - 1; k >= 0; k--) begin
      if (eligible[k] && (!bestValid || prioLevel_q[k] >= bestLevel)) begin
        bestValid = 1'b1;
        bestLevel = prioLevel_q[k];
        bestIdx = ipr_src_t'(k);
      end
    end
  end

  // Core level bit 3 marks trap processing, which keeps every source out
  assign takeReq = bestValid
    && ({1'b0, bestLevel} > cpuPriorityLevel);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuIrqReq_q <= 1'b0;
    end else begin
      cpuIrqReq_q <= takeReq;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuIrqVector_q <= 6'h00;
    end else begin
      cpuIrqVector_q <= bestIdx + `IPR_VEC_BASE;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuIrqLevel_q <= 3'h0;
    end else begin
      cpuIrqLevel_q <= bestLevel;
    end
  end

  // Block events: new core request, and a flag hit again while still pending
  always_comb begin
    evtSet = '0;
    evtSet[`IPR_EVT_REQ_BIT] = takeReq & ~cpuIrqReq_q;
    evtSet[`IPR_EVT_OVR_BIT] = |(srcEvent & flag_q & ~reserved);
  end

  // Write-one-to-clear; a set in the same cycle wins over the clear
  always_comb begin
    evtClr = '0;
    if (regWrStb && (regAddr == `IPR_OFS_EVT_STAT)) begin
      evtClr = regWrData[`IPR_EVT_W-1:0];
    end
  end

  assign evtStat_d = (evtStat_q & ~evtClr) | evtSet;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      evtStat_q <= `IPR_EVT_RST;
    end else begin
      evtStat_q <= evtStat_d;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      evtMask_q <= `IPR_EVT_RST;
    end else if (regWrStb && (regAddr == `IPR_OFS_EVT_MASK)) begin
      evtMask_q <= regWrData[`IPR_EVT_W-1:0];
    end
  end

  // Built from next-state values so the line follows status without extra lag
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      intOut_q <= 1'b0;
    end else if (regWrStb && (regAddr == `IPR_OFS_EVT_MASK)) begin
      intOut_q <= |(evtStat_d & regWrData[`IPR_EVT_W-1:0]);
    end else begin
      intOut_q <= |(evtStat_d & evtMask_q);
    end
  end

  // Read words are assembled per register at elaboration, so the select below
  // stays a flat mux; missing slots and sources are tied to zero
  genvar r;
  genvar s;
  generate
    for (r = 0; r < `IPR_NUM_PRIO_REGS; r++) begin : gPrioRd
      for (s = 0; s < `IPR_SLOTS_PER_REG; s++) begin : gSlot
        if (r * `IPR_SLOTS_PER_REG + s < `IPR_NUM_SRC) begin : gLive
          assign prioWord[r][s*`IPR_SLOT_W +: `IPR_SLOT_W] =
            {1'b0, prioLevel_q[r * `IPR_SLOTS_PER_REG + s]};
        end else begin : gGap
          assign prioWord[r][s*`IPR_SLOT_W +: `IPR_SLOT_W] = 4'h0;
        end
      end
    end
  endgenerate

  generate
    for (r = 0; r < `IPR_NUM_FLAG_REGS; r++) begin : gBitRd
      for (s = 0; s < `IPR_BITS_PER_REG; s++) begin : gBit
        if (r * `IPR_BITS_PER_REG + s < `IPR_NUM_SRC) begin : gLive
          assign flagWord[r][s] = flag_q[r * `IPR_BITS_PER_REG + s];
          assign enWord[r][s] = enable_q[r * `IPR_BITS_PER_REG + s];
        end else begin : gGap
          assign flagWord[r][s] = 1'b0;
          assign enWord[r][s] = 1'b0;
        end
      end
    end
  endgenerate

  // Read select; unmapped addresses read as zero
  always_comb begin
    rdMux = 16'h0000;
    if (regAddr < `IPR_OFS_PRIO + `IPR_ADDR_W'(`IPR_NUM_PRIO_REGS)) begin
      rdMux = prioWord[regAddr[3:0]];
    end else if ((regAddr >= `IPR_OFS_FLAG)
        && (regAddr < `IPR_OFS_FLAG + `IPR_ADDR_W'(`IPR_NUM_FLAG_REGS))) begin
      rdMux = flagWord[regAddr[1:0]];
    end else if ((regAddr >= `IPR_OFS_EN)
        && (regAddr < `IPR_OFS_EN + `IPR_ADDR_W'(`IPR_NUM_FLAG_REGS))) begin
      rdMux = enWord[regAddr[1:0]];
    end else if (regAddr == `IPR_OFS_RESULT) begin
      rdMux[`IPR_RES_VEC_LSB +: `IPR_SRC_W] = cpuIrqVector_q;
      rdMux[`IPR_RES_LVL_LSB +: `IPR_LVL_W] = cpuIrqLevel_q;
      rdMux[`IPR_RES_REQ_BIT] = cpuIrqReq_q;
    end else if (regAddr == `IPR_OFS_EVT_STAT) begin
      rdMux[`IPR_EVT_W-1:0] = evtStat_q;
    end else if (regAddr == `IPR_OFS_EVT_MASK) begin
      rdMux[`IPR_EVT_W-1:0] = evtMask_q;
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData_q <= 16'h0000;
    end else if (regRdStb) begin
      regRdData_q <= rdMux;
    end else begin
      regRdData_q <= 16'h0000;
    end
  end

endmodule

// ---- tb/ipr_core_model.sv ----
// Behavioural core: holds its priority level and can take an interrupt
`timescale 1ns/1ns
module ipr_core_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cpuIrqReq,
  input wire logic [2:0] cpuIrqLevel,
  input wire logic [3:0] lvlCmd,
  input wire logic lvlLoad,
  input wire logic takeEn,
  output logic [3:0] cpuPriorityLevel
);
  // Taking raises the level to the winner's, so equal and lower requests stay masked
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuPriorityLevel <= 4'h0;
    end else if (takeEn && cpuIrqReq) begin
      cpuPriorityLevel <= {1'b0, cpuIrqLevel};
    end else if (lvlLoad) begin
      cpuPriorityLevel <= lvlCmd;
    end
  end
endmodule

// ---- tb/ipr_resolver_sva.sv ----
// Checker on the resolver's core-side and register-read ports
`timescale 1ns/1ns
`include "ipr_cfg.svh"
module ipr_resolver_sva
  import ipr_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [`IPR_ADDR_W-1:0] regAddr,
  input wire logic regRdStb,
  input wire logic [`IPR_DATA_W-1:0] regRdData,
  input wire logic [`IPR_IPL_W-1:0] cpuPriorityLevel,
  input wire logic cpuIrqReq,
  input wire ipr_vector_t cpuIrqVector,
  input wire ipr_level_t cpuIrqLevel,
  input wire logic intOut
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  property p_req_exact;
    !$past(sys_rst) |-> cpuIrqReq == ({1'b0, cpuIrqLevel} > $past(cpuPriorityLevel));
  endproperty
  a_req_exact: assert property (p_req_exact) else $error("request vs core level");
  property p_top_blocks;
    $past(cpuPriorityLevel) >= 4'h7 |-> !cpuIrqReq;
  endproperty
  a_top_blocks: assert property (p_top_blocks) else $error("request above 7");
  property p_zero_off;
    cpuIrqReq |-> cpuIrqLevel != 3'h0;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("level 0 presented");
  property p_no_rsv;
    cpuIrqReq |-> !(cpuIrqVector inside {[6'h2F:6'h30], [6'h33:6'h3D]});
  endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved source won");
  property p_vec_range;
    !$past(sys_rst) |-> cpuIrqVector inside {[6'h08:6'h3D]};
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector out of range");
  property p_idle_vec;
    !$past(sys_rst) && cpuIrqLevel == 3'h0 |-> cpuIrqVector == 6'h08 && !cpuIrqReq;
  endproperty
  a_idle_vec: assert property (p_idle_vec) else $error("idle outputs wrong");
  property p_slot_top;
    $past(regRdStb) && $past(regAddr) < 8'h0E |-> (regRdData & 16'h8888) == 16'h0000;
  endproperty
  a_slot_top: assert property (p_slot_top) else $error("slot bit 3 set");
  property p_any_beats_zero;
    $past(cpuPriorityLevel) == 4'h0 && cpuIrqLevel != 3'h0 |-> cpuIrqReq;
  endproperty
  a_any_beats_zero: assert property (p_any_beats_zero) else $error("no request");
  c_top: cover property (cpuIrqReq && cpuIrqLevel == 3'h7);
  c_int: cover property ($rose(intOut));
  c_lvd: cover property (cpuIrqReq && cpuIrqVector == 6'h32);
endmodule

bind ipr_resolver ipr_resolver_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regRdStb(regRdStb), .regRdData(regRdData), .cpuPriorityLevel(cpuPriorityLevel),
  .cpuIrqReq(cpuIrqReq), .cpuIrqVector(cpuIrqVector), .cpuIrqLevel(cpuIrqLevel),
  .intOut(intOut));

// ---- tb/ipr_resolver_tb_top.sv ----
// Self-checking bench for the interrupt priority resolver
`timescale 1ns/1ns
module ipr_resolver_tb_top;
  logic mclk = 0, sysRst = 1, wS = 0, rS = 0, lvlLoad = 0, takeEn = 0, req, intOut;
  logic [7:0] a = 8'h00;
  logic [15:0] wD = 16'h0000, rD;
  logic [53:0] ev = '0;
  logic [10:0] pins = '0;
  logic [3:0] lvlCmd = 4'h0, cpuLvl;
  logic [5:0] vec;
  logic [2:0] lv;
  int nFail = 0, checksDone = 0, seed = 32'hBBF0, lvl = 0;
  int prio[54], flg[54], en[54];
  int pinSrc[11] = '{0, 16, 23, 36, 37, 9, 10, 24, 25, 41, 42};
  ipr_resolver DUT (.mclk(mclk), .sys_rst(sysRst), .regAddr(a), .regWrData(wD),
    .regWrStb(wS), .regRdStb(rS), .regRdData(rD), .periphEvent(ev), .extPinIrqA(pins[0]),
    .extPinIrqB(pins[1]), .extPinIrqC(pins[2]), .extPinIrqD(pins[3]), .extPinIrqE(pins[4]),
    .serialAReceiveIrq(pins[5]), .serialATransmitIrq(pins[6]), .serialBReceiveIrq(pins[7]),
    .serialBTransmitIrq(pins[8]), .codecTransferIrq(pins[9]), .lowVoltageDetectIrq(pins[10]),
    .cpuPriorityLevel(cpuLvl), .cpuIrqReq(req), .cpuIrqVector(vec), .cpuIrqLevel(lv),
    .intOut(intOut));
  ipr_core_model core (.mclk(mclk), .sys_rst(sysRst), .cpuIrqReq(req), .cpuIrqLevel(lv),
    .lvlCmd(lvlCmd), .lvlLoad(lvlLoad), .takeEn(takeEn), .cpuPriorityLevel(cpuLvl));
  task automatic chk(bit ok, string m);
    checksDone++;
    if (!ok) begin
      $display("CHECK FAILED at %0t: %s", $time, m);
      nFail++;
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, failures %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] ad, logic [15:0] d);
    @(posedge mclk);
    a <= ad;
    wD <= d;
    wS <= 1'b1;
    @(posedge mclk);
    wS <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, logic [15:0] e);
    @(posedge mclk);
    a <= ad;
    rS <= 1'b1;
    @(posedge mclk);
    rS <= 1'b0;
    #1 chk(rD === e, "read data");
  endtask
  task automatic pulse(int tk, logic [53:0] e, logic [10:0] p);
    @(posedge mclk);
    ev <= e;
    pins <= p;
    takeEn <= tk[0];
    lvlCmd <= 4'(tk >> 1);
    lvlLoad <= !tk[0];
    @(posedge mclk);
    {ev, pins, takeEn, lvlLoad} <= '0;
    for (int i = 0; i < 65; i++)
      if (i < 54 ? e[i] && !(i inside {[39:40], [43:53]}) : p[i - 54])
        flg[i < 54 ? i : pinSrc[i - 54]] = 1;
  endtask
  task automatic cmpOut();
    int b;
    b = -1;
    for (int i = 0; i < 54; i++)
      if (flg[i] && en[i] && prio[i] != 0 && (b < 0 || prio[i] > prio[b])) b = i;
    repeat (2) @(posedge mclk);
    #1 chk(vec === 6'(b < 0 ? 8 : b + 8), "vector");
    chk(lv === 3'(b < 0 ? 0 : prio[b]), "level");
    chk(req === (b >= 0 && prio[b] > lvl), "request");
  endtask
  task automatic setUp(int fix, logic [15:0] e);
    logic [15:0] d;
    for (int r = 0; r < 18; r++) begin
      d = r > 13 ? e : fix < 0 ? 16'($random(seed)) : 16'(fix);
      wr(r > 13 ? 8'(r + 6) : 8'(r), r > 13 ? d : 16'h0000 | d);
      for (int j = 0; j < 16; j++)
        if (r > 13 && r * 16 + j < 278)
          en[r * 16 + j - 224] = d[j] && !((r * 16 + j - 224) inside {[39:40], [43:53]});
        else if (r < 14 && j < 4 && r * 4 + j < 54)
          prio[r * 4 + j] = d[j * 4 +: 3];
      if (r < 14) rd(8'(r), d & (r == 13 ? 16'h0077 : 16'h7777));
    end
  endtask
  task automatic clr();
    for (int r = 0; r < 4; r++) wr(8'h10 + 8'(r), 16'h0000);
    flg = '{default: 0};
  endtask
  task automatic intChk(bit e);
    repeat (2) @(posedge mclk);
    #1 chk(intOut === e, "interrupt line");
  endtask
  initial begin
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    nFail++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge mclk);
    sysRst <= 1'b0;
    cmpOut();
    rd(8'h30, 16'h0000);
    setUp(16'h3333, 16'hFFFF);
    rd(8'h16, 16'h067F);
    pulse(0, '1, '0);
    cmpOut();
    rd(8'h12, 16'h067F);
    wr(8'h00, 16'h3331);
    wr(8'h0A, 16'h3733);
    prio[0] = 1;
    prio[42] = 7;
    cmpOut();
    rd(8'h19, 16'h0001);
    intChk(1'b0);
    wr(8'h1A, 16'h0001);
    intChk(1'b1);
    wr(8'h19, 16'h0001);
    intChk(1'b0);
    pulse(0, 54'h20, '0);
    rd(8'h19, 16'h0002);
    wr(8'h1A, 16'h0003);
    intChk(1'b1);
    pulse(1, '0, '0);
    lvl = 7;
    cmpOut();
    for (int n = 0; n < 40; n++) begin
      clr();
      setUp(-1, 16'($random(seed)));
      lvl = {$random(seed)} % 10;
      pulse(lvl * 2, 54'({$random(seed), $random(seed)}), 11'($random(seed)));
      cmpOut();
    end
    lvl = 0;
    pulse(0, '0, '0);
    setUp(16'h1111, 16'hFFFF);
    for (int i = 0; i < 11; i++) begin
      clr();
      pulse(0, '0, 11'(1) << i);
      cmpOut();
    end
    conclude();
  end
endmodule
